// ### verilog/pcc_pkg.sv
// constants for the pci configuration cycle generator
// assumes a host i/o port on the bridge clock and a transaction-level pci master port
package pcc_pkg;
  localparam logic [15:0] ADDR_PORT = 16'h0cf8;
  localparam logic [15:0] DATA_PORT = 16'h0cfc;
  localparam logic [31:0] TARGET_SELECT_RESET = 32'h0000_0000;
  localparam logic [3:0] BE_DWORD = 4'hf;
  // target select word fields
  localparam int GATE_BIT = 31;
  localparam int BUS_HI = 23;
  localparam int BUS_LO = 16;
  localparam int DEV_HI = 15;
  localparam int DEV_LO = 11;
  localparam int FN_HI = 10;
  localparam int FN_LO = 8;
  localparam int REG_HI = 7;
  localparam int REG_LO = 2;
  localparam logic [31:0] WRITABLE_MASK = 32'h80ff_fffc;
  localparam logic [7:0] OWN_BUS = 8'h00;
  localparam logic [4:0] SPECIAL_DEV = 5'h1f;
  localparam logic [2:0] SPECIAL_FN = 3'h7;
  localparam logic [5:0] SPECIAL_REG = 6'h00;
  localparam logic [1:0] TYPE0_CODE = 2'h0;
  localparam logic [1:0] TYPE1_CODE = 2'h1;
  // pci bus commands
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_IO_READ = 4'h2;
  localparam logic [3:0] CMD_IO_WRITE = 4'h3;
  localparam logic [3:0] CMD_CFG_READ = 4'ha;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hb;
  // hard-coded broadcast messages
  localparam logic [31:0] MSG_SHUTDOWN = 32'h0000_0000;
  localparam logic [31:0] MSG_HALT = 32'h0000_0001;
endpackage : pcc_pkg

// ### verilog/pcc_txn_if.sv
// request/answer carrier between the bridge decoder and the pci sequencer
// assumes both ends on the same clock; req is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
interface pcc_txn_if;
  logic req;
  logic [3:0] cmd;
  logic [31:0] addr;
  logic [3:0] be;
  logic [31:0] wdata;
  logic done;
  logic [31:0] rdata;
  modport issuer (output req, output cmd, output addr, output be, output wdata,
    input done, input rdata);
  modport runner (input req, input cmd, input addr, input be, input wdata,
    output done, output rdata);
endinterface : pcc_txn_if
`default_nettype wire

// ### verilog/pcc_pci_seq.sv
// pci master sequencer: holds one transaction on the pci port until the bus answers
// assumes pci_done comes from same-clock logic and pulses once per transaction
`timescale 1ns/100ps
`default_nettype none
module pcc_pci_seq (
  input wire logic clock,
  input wire logic reset,
  pcc_txn_if.runner txn,
  output logic pci_valid,
  output logic [3:0] pci_cmd,
  output logic [31:0] pci_addr,
  output logic [3:0] pci_be,
  output logic [31:0] pci_wdata,
  input wire logic pci_done,
  input wire logic [31:0] pci_rdata
);
  logic next_pci_valid;
  logic [3:0] next_pci_cmd;
  logic [31:0] next_pci_addr;
  logic [3:0] next_pci_be;
  logic [31:0] next_pci_wdata;
  logic done_q;
  logic next_done_q;
  logic [31:0] rdata_q;
  logic [31:0] next_rdata_q;

  always_comb
  begin
    next_pci_valid = pci_valid;
    next_pci_cmd = pci_cmd;
    next_pci_addr = pci_addr;
    next_pci_be = pci_be;
    next_pci_wdata = pci_wdata;
    next_done_q = 1'b0;
    next_rdata_q = rdata_q;
    if (!pci_valid && txn.req)
    begin
      next_pci_valid = 1'b1;
      next_pci_cmd = txn.cmd;
      next_pci_addr = txn.addr;
      next_pci_be = txn.be;
      next_pci_wdata = txn.wdata;
    end
    else if (pci_valid && pci_done)
    begin
      next_pci_valid = 1'b0;
      next_done_q = 1'b1;
      next_rdata_q = pci_rdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pci_valid <= 1'b0;
      pci_cmd <= 4'h0;
      pci_addr <= 32'h0000_0000;
      pci_be <= 4'h0;
      pci_wdata <= 32'h0000_0000;
      done_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      pci_valid <= next_pci_valid;
      pci_cmd <= next_pci_cmd;
      pci_addr <= next_pci_addr;
      pci_be <= next_pci_be;
      pci_wdata <= next_pci_wdata;
      done_q <= next_done_q;
      rdata_q <= next_rdata_q;
    end
  end

  assign txn.done = done_q;
  assign txn.rdata = rdata_q;
endmodule : pcc_pci_seq
`default_nettype wire

// ### verilog/pcc_bridge.sv
// host i/o to pci configuration and special cycle bridge
// assumes io_req is a one-cycle pulse, at most one request outstanding
`timescale 1ns/100ps
`default_nettype none
module pcc_bridge (
  input wire logic clock,
  input wire logic reset,
  input wire logic io_req,
  input wire logic io_write,
  input wire logic [15:0] io_addr,
  input wire logic [3:0] io_be,
  input wire logic [31:0] io_wdata,
  output logic io_ready,
  output logic [31:0] io_rdata,
  input wire logic halt_req,
  input wire logic shutdown_req,
  output logic pci_valid,
  output logic [3:0] pci_cmd,
  output logic [31:0] pci_addr,
  output logic [3:0] pci_be,
  output logic [31:0] pci_wdata,
  input wire logic pci_done,
  input wire logic [31:0] pci_rdata
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } pcc_state_e;

  pcc_state_e state;
  pcc_state_e next_state;
  logic [31:0] cfg_target_select;
  logic [31:0] next_cfg_target_select;
  logic halt_pend;
  logic next_halt_pend;
  logic shut_pend;
  logic next_shut_pend;
  logic next_io_ready;
  logic [31:0] next_io_rdata;
  logic reply_pend;
  logic next_reply_pend;

  pcc_txn_if txn ();

  ////////////////////////////////////////////////////////////////////////////
  // address word decoding

  // one-hot idsel on ad[31:11]; devices above 20 get no select line
  function automatic logic [31:0] cfg_address(input logic [31:0] sel);
    logic [31:0] a;
    logic [4:0] dev;
    a = 32'h0000_0000;
    dev = sel[pcc_pkg::DEV_HI:pcc_pkg::DEV_LO];
    if (sel[pcc_pkg::BUS_HI:pcc_pkg::BUS_LO] == pcc_pkg::OWN_BUS)
    begin
      if (dev < 5'h15)
        a[32'd11 + {27'h0, dev}] = 1'b1;
      a[pcc_pkg::FN_HI:pcc_pkg::FN_LO] = sel[pcc_pkg::FN_HI:pcc_pkg::FN_LO];
      a[pcc_pkg::REG_HI:pcc_pkg::REG_LO] = sel[pcc_pkg::REG_HI:pcc_pkg::REG_LO];
      a[1:0] = pcc_pkg::TYPE0_CODE;
    end
    else
    begin
      a[pcc_pkg::BUS_HI:pcc_pkg::REG_LO] = sel[pcc_pkg::BUS_HI:pcc_pkg::REG_LO];
      a[1:0] = pcc_pkg::TYPE1_CODE;
    end
    return a;
  endfunction : cfg_address

  // special-cycle code as the host must write it
  function automatic logic is_special(input logic [31:0] sel);
    return sel[pcc_pkg::GATE_BIT]
      && sel[pcc_pkg::DEV_HI:pcc_pkg::DEV_LO] == pcc_pkg::SPECIAL_DEV
      && sel[pcc_pkg::FN_HI:pcc_pkg::FN_LO] == pcc_pkg::SPECIAL_FN
      && sel[pcc_pkg::REG_HI:pcc_pkg::REG_LO] == pcc_pkg::SPECIAL_REG;
  endfunction : is_special

  logic cfg_cycle_gate;
  logic hit_addr_word;
  logic hit_data_win;
  assign cfg_cycle_gate = cfg_target_select[pcc_pkg::GATE_BIT];
  assign hit_addr_word = io_addr == pcc_pkg::ADDR_PORT && io_be == pcc_pkg::BE_DWORD;
  assign hit_data_win = io_addr == pcc_pkg::DATA_PORT && cfg_cycle_gate;

  ////////////////////////////////////////////////////////////////////////////
  // request steering

  always_comb
  begin
    next_state = state;
    next_cfg_target_select = cfg_target_select;
    next_halt_pend = halt_pend;
    next_shut_pend = shut_pend;
    next_io_ready = 1'b0;
    next_io_rdata = io_rdata;
    next_reply_pend = reply_pend;
    txn.req = 1'b0;
    txn.cmd = pcc_pkg::CMD_IO_READ;
    txn.addr = {16'h0000, io_addr};
    txn.be = io_be;
    txn.wdata = io_wdata;
    unique case (state)
      ST_IDLE:
      begin
        if (io_req && hit_addr_word)
        begin
          // address word answers locally in one cycle
          next_io_ready = 1'b1;
          if (io_write)
            next_cfg_target_select = io_wdata & pcc_pkg::WRITABLE_MASK;
          else
            next_io_rdata = cfg_target_select;
        end
        else if (io_req)
        begin
          txn.req = 1'b1;
          next_reply_pend = 1'b1;
          next_state = ST_WAIT;
          if (!hit_data_win)
            txn.cmd = io_write ? pcc_pkg::CMD_IO_WRITE : pcc_pkg::CMD_IO_READ;
          else if (io_write && is_special(cfg_target_select)
            && cfg_target_select[pcc_pkg::BUS_HI:pcc_pkg::BUS_LO] == pcc_pkg::OWN_BUS)
          begin
            txn.cmd = pcc_pkg::CMD_SPECIAL;
            txn.addr = 32'h0000_0000;
          end
          else
          begin
            // special code on another bus becomes a type 1 write, bridges convert it
            txn.cmd = io_write ? pcc_pkg::CMD_CFG_WRITE : pcc_pkg::CMD_CFG_READ;
            txn.addr = cfg_address(cfg_target_select);
          end
        end
        else if (halt_pend || shut_pend)
        begin
          // processor requests wait behind host i/o; no reply goes back
          txn.req = 1'b1;
          txn.cmd = pcc_pkg::CMD_SPECIAL;
          txn.addr = 32'h0000_0000;
          txn.be = pcc_pkg::BE_DWORD;
          txn.wdata = halt_pend ? pcc_pkg::MSG_HALT : pcc_pkg::MSG_SHUTDOWN;
          next_halt_pend = 1'b0;
          next_shut_pend = halt_pend ? shut_pend : 1'b0;
          next_reply_pend = 1'b0;
          next_state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (txn.done)
        begin
          next_state = ST_IDLE;
          next_reply_pend = 1'b0;
          next_io_ready = reply_pend;
          if (reply_pend)
            next_io_rdata = txn.rdata;
        end
      end
    endcase
    // a new request in the cycle its flag clears is kept
    if (halt_req)
      next_halt_pend = 1'b1;
    if (shutdown_req)
      next_shut_pend = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      cfg_target_select <= pcc_pkg::TARGET_SELECT_RESET;
      halt_pend <= 1'b0;
      shut_pend <= 1'b0;
      io_ready <= 1'b0;
      io_rdata <= 32'h0000_0000;
      reply_pend <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cfg_target_select <= next_cfg_target_select;
      halt_pend <= next_halt_pend;
      shut_pend <= next_shut_pend;
      io_ready <= next_io_ready;
      io_rdata <= next_io_rdata;
      reply_pend <= next_reply_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pci master

  pcc_pci_seq u_seq (
    .clock(clock),
    .reset(reset),
    .txn(txn.runner),
    .pci_valid(pci_valid),
    .pci_cmd(pci_cmd),
    .pci_addr(pci_addr),
    .pci_be(pci_be),
    .pci_wdata(pci_wdata),
    .pci_done(pci_done),
    .pci_rdata(pci_rdata)
  );
endmodule : pcc_bridge
`default_nettype wire

// ### bench/pcc_bridge_sva.sv
// checker for the config cycle bridge, bound to its top module
// assumes the bench never overlaps host requests with halt or shutdown
`timescale 1ns/100ps
`default_nettype none
module pcc_bridge_sva (
  input wire logic clock,
  input wire logic reset,
  input wire logic io_req,
  input wire logic io_write,
  input wire logic io_ready,
  input wire logic halt_req,
  input wire logic [15:0] io_addr,
  input wire logic [3:0] io_be,
  input wire logic [31:0] io_wdata,
  input wire logic [31:0] io_rdata,
  input wire logic pci_valid,
  input wire logic pci_done,
  input wire logic [3:0] pci_cmd,
  input wire logic [3:0] pci_be,
  input wire logic [31:0] pci_addr,
  input wire logic [31:0] pci_wdata,
  input wire logic [31:0] pci_rdata
);
  logic busy, next_busy, take, dw, pass_io;
  logic [31:0] word, next_word;
  assign take = io_req && !busy && !pci_valid;
  assign dw = io_addr == pcc_pkg::ADDR_PORT && io_be == pcc_pkg::BE_DWORD;
  assign pass_io = io_addr != pcc_pkg::DATA_PORT && !dw;
  // mirror of the address word, so type and gate checks need no internal probe
  always_comb
  begin
    next_busy = io_ready ? 1'b0 : busy | take;
    next_word = take && io_write && dw ? io_wdata & pcc_pkg::WRITABLE_MASK : word;
  end
  always_ff @(posedge clock)
  begin
    busy <= reset ? 1'b0 : next_busy;
    word <= reset ? '0 : next_word;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_rd_done;
    pci_valid && pci_done && pci_cmd == pcc_pkg::CMD_CFG_READ;
  endsequence
  sequence s_cfg_rd;
    take && !io_write && io_addr == pcc_pkg::DATA_PORT && word[31];
  endsequence
  a_word_ack: assert property (take && dw |=> io_ready && !pci_valid)
    else $error("address word access not answered next cycle");
  a_io_pass: assert property (take && pass_io && io_write |=> pci_valid
    && pci_cmd == pcc_pkg::CMD_IO_WRITE && pci_addr[15:0] == $past(io_addr)
    && pci_be == $past(io_be))
    else $error("plain io write not forwarded");
  a_gate_cmd: assert property (take && !io_write && io_addr == pcc_pkg::DATA_PORT
    |=> pci_valid && pci_cmd == (word[31] ? pcc_pkg::CMD_CFG_READ : pcc_pkg::CMD_IO_READ))
    else $error("data port read has wrong command");
  a_type_sel: assert property (s_cfg_rd |=> pci_addr[10:2] == word[10:2]
    && pci_addr[1:0] == (word[23:16] == pcc_pkg::OWN_BUS ? 2'h0 : 2'h1))
    else $error("config address or type wrong");
  a_pci_hold: assert property (pci_valid && !pci_done |=> pci_valid
    && $stable(pci_addr) && $stable(pci_cmd) && $stable(pci_wdata))
    else $error("pci request changed before done");
  a_pci_drop: assert property (pci_valid && pci_done |=> !pci_valid)
    else $error("pci valid held after done");
  a_rd_answer: assert property (s_rd_done |=> !io_ready ##1 io_ready
    && io_rdata == $past(pci_rdata, 2))
    else $error("config read data not returned");
  a_halt_msg: assert property (halt_req && !io_req && !busy && !pci_valid
    |=> ##[0:2] pci_valid && pci_cmd == pcc_pkg::CMD_SPECIAL && pci_be == pcc_pkg::BE_DWORD
    && pci_wdata == pcc_pkg::MSG_HALT)
    else $error("halt special cycle missing");
endmodule : pcc_bridge_sva
bind pcc_bridge pcc_bridge_sva chk (
  .clock(clock), .reset(reset), .io_req(io_req), .io_write(io_write), .io_ready(io_ready),
  .halt_req(halt_req), .io_addr(io_addr), .io_be(io_be), .io_wdata(io_wdata),
  .io_rdata(io_rdata), .pci_valid(pci_valid), .pci_done(pci_done), .pci_cmd(pci_cmd),
  .pci_be(pci_be), .pci_addr(pci_addr), .pci_wdata(pci_wdata), .pci_rdata(pci_rdata)
);
`default_nettype wire

// ### bench/pcc_pci_target.sv
// pci side target model: raises pci_done lag+1 cycles after pci_valid rises
// assumes the bridge holds its request until pci_done is seen
`timescale 1ns/100ps
`default_nettype none
module pcc_pci_target (
  input wire logic clock,
  input wire logic reset,
  input wire logic pci_valid,
  input wire logic [3:0] pci_cmd,
  input wire logic [3:0] lag,
  input wire logic [31:0] pci_addr,
  input wire logic [31:0] pci_wdata,
  output logic pci_done,
  output logic [31:0] pci_rdata,
  output logic [31:0] seen_addr,
  output logic [31:0] seen_wdata,
  output logic [3:0] seen_cmd,
  output logic [7:0] n_seen
);
  logic [3:0] cnt;
  // read data toggles outside done so stale data never passes
  always_ff @(posedge clock)
  begin
    pci_done <= 1'b0;
    pci_rdata <= ~pci_rdata;
    if (reset)
    begin
      cnt <= '0;
      n_seen <= '0;
      pci_rdata <= '0;
    end
    else if (pci_valid && !pci_done)
    begin
      cnt <= cnt + 4'h1;
      if (cnt == lag)
      begin
        cnt <= '0;
        pci_done <= 1'b1;
        pci_rdata <= ~pci_addr;
        seen_cmd <= pci_cmd;
        seen_addr <= pci_addr;
        seen_wdata <= pci_wdata;
        n_seen <= n_seen + 8'h1;
      end
    end
  end
endmodule : pcc_pci_target
`default_nettype wire

// ### bench/test_pci_config_cycle_generator.sv
// self-checking bench for the config cycle bridge and a pci target model
// assumes the checker is bound from its own file
`timescale 1ns/100ps
`default_nettype none
module test_pci_config_cycle_generator;
  logic clock = 0, reset = 1, io_req = 0, io_write = 0, halt_req = 0, shutdown_req = 0;
  logic [15:0] io_addr = '0;
  logic [3:0] io_be = '0, lag = '0, pci_cmd, pci_be, seen_cmd;
  logic [31:0] io_wdata = '0, io_rdata, pci_addr, pci_wdata, pci_rdata, seen_addr;
  logic [31:0] seen_wdata, rd;
  logic io_ready, pci_valid, pci_done;
  logic [7:0] n_seen;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  pcc_bridge dut (
    .clock(clock), .reset(reset), .io_req(io_req), .io_write(io_write), .io_addr(io_addr),
    .io_be(io_be), .io_wdata(io_wdata), .io_ready(io_ready), .io_rdata(io_rdata),
    .halt_req(halt_req), .shutdown_req(shutdown_req), .pci_valid(pci_valid),
    .pci_cmd(pci_cmd), .pci_addr(pci_addr), .pci_be(pci_be), .pci_wdata(pci_wdata),
    .pci_done(pci_done), .pci_rdata(pci_rdata)
  );
  pcc_pci_target far (
    .clock(clock), .reset(reset), .pci_valid(pci_valid), .pci_cmd(pci_cmd), .lag(lag),
    .pci_addr(pci_addr), .pci_wdata(pci_wdata), .pci_done(pci_done), .pci_rdata(pci_rdata),
    .seen_addr(seen_addr), .seen_wdata(seen_wdata), .seen_cmd(seen_cmd), .n_seen(n_seen)
  );
  initial forever #20 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic io(input logic w, input logic [15:0] a, input logic [3:0] b,
    input logic [31:0] d);
    int k;
    @(posedge clock);
    io_req <= 1'b1;
    io_write <= w;
    io_addr <= a;
    io_be <= b;
    io_wdata <= d;
    @(posedge clock);
    io_req <= 1'b0;
    k = 0;
    // io_ready stands one cycle: read it at the edge that samples it
    do
    begin
      @(posedge clock);
      k++;
    end while (io_ready !== 1'b1 && k < 60);
    check({31'h0, io_ready}, 32'h1);
    rd = io_rdata;
  endtask : io
  task automatic seen(input logic [3:0] c, input logic [31:0] a);
    check({28'h0, seen_cmd}, {28'h0, c});
    check(seen_addr, a);
  endtask : seen
  task automatic special(input logic h, input logic [31:0] msg);
    int k;
    logic [7:0] n0;
    n0 = n_seen;
    @(posedge clock);
    halt_req <= h;
    shutdown_req <= !h;
    @(posedge clock);
    halt_req <= 1'b0;
    shutdown_req <= 1'b0;
    for (k = 0; k < 60 && (n_seen == n0 || pci_valid === 1'b1); k++)
    begin
      @(posedge clock);
      #1;
    end
    check({28'h0, seen_cmd}, 32'h1);
    check(seen_wdata, msg);
  endtask : special
  initial
  begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    io(0, 16'h0cf8, 4'hf, 0);
    check(rd, 32'h0);
    io(1, 16'h0cf8, 4'hf, 32'hffff_ffff);
    io(0, 16'h0cf8, 4'hf, 0);
    check(rd, 32'h80ff_fffc);
    $display("test 1 done");
    io(1, 16'h0cf8, 4'hf, 0);
    io(0, 16'h0cfc, 4'hf, 0);
    seen(4'h2, 32'h0000_0cfc);
    check(rd, 32'hffff_f303);
    $display("test 2 done");
    lag <= 4'h3;
    io(1, 16'h0cf8, 4'hf, 32'h8000_1314);
    io(1, 16'h0cfc, 4'hf, 32'h1234_5678);
    seen(4'hb, 32'h0000_2314);
    check(seen_wdata, 32'h1234_5678);
    io(0, 16'h0cfc, 4'hf, 0);
    seen(4'ha, 32'h0000_2314);
    check(rd, 32'hffff_dceb);
    $display("test 3 done");
    lag <= 4'h0;
    io(1, 16'h0cf8, 4'hf, 32'h80a5_1314);
    io(0, 16'h0cfc, 4'hf, 0);
    seen(4'ha, 32'h00a5_1315);
    check(rd, 32'hff5a_ecea);
    $display("test 4 done");
    io(1, 16'h0cf8, 4'h3, 32'h1);
    seen(4'h3, 32'h0000_0cf8);
    io(0, 16'h0cf8, 4'hf, 0);
    check(rd, 32'h80a5_1314);
    $display("test 5 done");
    io(1, 16'h0cf8, 4'hf, 32'h8000_ff00);
    io(1, 16'h0cfc, 4'hf, 32'h0000_abcd);
    seen(4'h1, 32'h0);
    check(seen_wdata, 32'h0000_abcd);
    io(1, 16'h0cf8, 4'hf, 32'h8001_ff00);
    io(1, 16'h0cfc, 4'hf, 32'h0000_0011);
    seen(4'hb, 32'h0001_ff01);
    check(seen_wdata, 32'h0000_0011);
    $display("test 6 done");
    special(1'b1, 32'h1);
    special(1'b0, 32'h0);
    $display("test 7 done");
    print_verdict();
  end
endmodule : test_pci_config_cycle_generator
`default_nettype wire
